// ---- rls_defines.svh ----
// constants for the receive lane sync status block
//
// Operation
// - Each of the 20 lanes drives its own 2-bit count of sync header framing errors.
// - Each lane count has a 1-bit valid strobe and is meaningful only while that strobe is 1.
// - The combined local fault output is high one cycle after the internal or the received fault is high.
// - A 20-bit level vector shows per lane that word lock is held and a lane marker was received.
// - A 20-bit level vector flags per lane a lock loss by header errors or a marker never seen.
// - A 20-bit vector flags per lane markers off the configured interval, held until spacing is good.
// - A 20-bit vector flags per lane four consecutive marker errors, held until the errors stop.
// - A valid count is an increment that may change every cycle, for a per-lane counter outside.
`ifndef RLS_DEFINES_SVH
`define RLS_DEFINES_SVH

// ----------------------------------------------------------------
// sizes
// ----------------------------------------------------------------
`define RLS_NUM_LANES    20
`define RLS_FERR_W       2
`define RLS_INTV_W       16
`define RLS_REP_W        3
`define RLS_REP_LIMIT    3'h4
`define RLS_ADDR_W       8

// ----------------------------------------------------------------
// register map and reset values
// ----------------------------------------------------------------
`define RLS_REG_CTRL     8'h00
`define RLS_REG_SYNCED   8'h04
`define RLS_REG_SYNCERR  8'h08
`define RLS_REG_SPACING  8'h0C
`define RLS_REG_REPEAT   8'h10
`define RLS_REG_IRQ_ST   8'h14
`define RLS_REG_IRQ_MASK 8'h18
`define RLS_REG_FAULT    8'h1C
`define RLS_INTV_RST     16'h3FFF
`define RLS_IRQ_W        4
`define RLS_IRQ_MASK_RST 4'h0

// ----------------------------------------------------------------
// interrupt status bit positions
// ----------------------------------------------------------------
`define RLS_IRQ_SYNCERR  0
`define RLS_IRQ_SPACING  1
`define RLS_IRQ_REPEAT   2
`define RLS_IRQ_FAULT    3

`endif

// ---- rls_pkg.sv ----
// types shared by the receive lane sync status block
package rls_pkg;

    // per-lane word lock tracking
    typedef enum logic [1:0] {
        RLS_HUNT,
        RLS_WAIT_MARK,
        RLS_SYNCED
    } rls_lane_state_e;

endpackage

// ---- rls_lane_track.sv ----
// per-lane lock, marker spacing and framing error tracker
`include "rls_defines.svh"

module rls_lane_track #(
    parameter int INTV_W = `RLS_INTV_W
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    // lane decoder side
    input  wire logic              lock_in,
    input  wire logic              word_in,
    input  wire logic              marker_in,
    input  wire logic              marker_bad_in,
    input  wire logic [1:0]        ferr_cnt_in,
    input  wire logic              ferr_stb_in,
    // configuration
    input  wire logic [INTV_W-1:0] marker_interval_setting,
    // status
    output logic [1:0]             ferr_value,
    output logic                   ferr_valid,
    output logic                   synced,
    output logic                   sync_err,
    output logic                   marker_spacing_error,
    output logic                   marker_repeat_error
);

    rls_pkg::rls_lane_state_e  st_r, st_nxt;
    logic [INTV_W-1:0]         wcnt_r, wcnt_nxt;
    logic [`RLS_REP_W-1:0]     rep_r, rep_nxt;
    logic [1:0]                fval_r, fval_nxt;
    logic                      fvld_r, fvld_nxt;
    logic                      serr_r, serr_nxt;
    logic                      spc_r, spc_nxt;
    logic                      rep_err_r, rep_err_nxt;
    logic                      late;
    logic                      off;

    always_comb begin
        st_nxt      = st_r;
        wcnt_nxt    = wcnt_r;
        rep_nxt     = rep_r;
        serr_nxt    = serr_r;
        spc_nxt     = spc_r;
        // count valid only with its strobe, same cycle
        fvld_nxt    = ferr_stb_in;
        fval_nxt    = ferr_stb_in ? ferr_cnt_in : 2'h0;
        late = word_in && !marker_in && (wcnt_r == marker_interval_setting);
        off  = marker_in && (wcnt_r != marker_interval_setting);
        if (word_in) begin
            if (marker_in) begin
                wcnt_nxt = '0;
            end else if (wcnt_r != '1) begin
                wcnt_nxt = wcnt_r + 1'b1;
            end
        end
        case (st_r)
            rls_pkg::RLS_HUNT: begin
                if (lock_in) begin
                    st_nxt   = rls_pkg::RLS_WAIT_MARK;
                    wcnt_nxt = '0;
                end
            end
            rls_pkg::RLS_WAIT_MARK: begin
                if (!lock_in) begin
                    st_nxt   = rls_pkg::RLS_HUNT;
                    serr_nxt = 1'b1;
                end else if (marker_in && word_in && !marker_bad_in) begin
                    st_nxt   = rls_pkg::RLS_SYNCED;
                    serr_nxt = 1'b0;
                end else if (late) begin
                    serr_nxt = 1'b1;
                end
            end
            rls_pkg::RLS_SYNCED: begin
                if (!lock_in) begin
                    st_nxt   = rls_pkg::RLS_HUNT;
                    serr_nxt = 1'b1;
                    spc_nxt  = 1'b0;
                    rep_nxt  = '0;
                end else if (word_in && (off || late || (marker_in && marker_bad_in))) begin
                    if (off || late) begin
                        spc_nxt = 1'b1;
                    end
                    if (rep_r != `RLS_REP_LIMIT) begin
                        rep_nxt = rep_r + 1'b1;
                    end
                end else if (word_in && marker_in) begin
                    spc_nxt = 1'b0;
                    rep_nxt = '0;
                end
            end
            default: begin
                st_nxt = rls_pkg::RLS_HUNT;
            end
        endcase
        rep_err_nxt = (rep_nxt == `RLS_REP_LIMIT);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r      <= rls_pkg::RLS_HUNT;
            wcnt_r    <= '0;
            rep_r     <= '0;
            fval_r    <= 2'h0;
            fvld_r    <= 1'b0;
            serr_r    <= 1'b0;
            spc_r     <= 1'b0;
            rep_err_r <= 1'b0;
        end else begin
            st_r      <= st_nxt;
            wcnt_r    <= wcnt_nxt;
            rep_r     <= rep_nxt;
            fval_r    <= fval_nxt;
            fvld_r    <= fvld_nxt;
            serr_r    <= serr_nxt;
            spc_r     <= spc_nxt;
            rep_err_r <= rep_err_nxt;
        end
    end

    assign ferr_value           = fval_r;
    assign ferr_valid           = fvld_r;
    assign synced               = (st_r == rls_pkg::RLS_SYNCED);
    assign sync_err             = serr_r;
    assign marker_spacing_error = spc_r;
    assign marker_repeat_error  = rep_err_r;

endmodule

// ---- rls_sync_status.sv ----
// receive lane sync status top with apb registers and interrupt
`include "rls_defines.svh"

module rls_sync_status #(
    parameter int LANES  = `RLS_NUM_LANES,
    parameter int INTV_W = `RLS_INTV_W
) (
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst,

    // apb slave
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [`RLS_ADDR_W-1:0] paddr,
    input  wire logic [31:0]          pwdata,
    output logic [31:0]               prdata,
    output logic                      pready,
    output logic                      pslverr,

    // lane decoder and aligner side
    input  wire logic [LANES-1:0]     lane_lock,
    input  wire logic [LANES-1:0]     lane_word,
    input  wire logic [LANES-1:0]     lane_marker,
    input  wire logic [LANES-1:0]     lane_marker_bad,
    input  wire logic [2*LANES-1:0]   lane_ferr_cnt,
    input  wire logic [LANES-1:0]     lane_ferr_stb,

    // fault sources
    input  wire logic                 internal_local_fault,
    input  wire logic                 received_local_fault,

    // framing error increments, two bits per lane
    output logic [2*LANES-1:0]        framing_err,
    output logic [LANES-1:0]          framing_err_valid,

    // lane status vectors
    output logic [LANES-1:0]          lane_synced,
    output logic [LANES-1:0]          lane_sync_err,
    output logic [LANES-1:0]          marker_spacing_error,
    output logic [LANES-1:0]          marker_repeat_error,

    // combined fault and interrupt
    output logic                      local_fault,
    output logic                      irq
);

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    logic [INTV_W-1:0]        intv_r, intv_nxt;
    logic [`RLS_IRQ_W-1:0]    irq_st_r, irq_st_nxt;
    logic [`RLS_IRQ_W-1:0]    irq_mask_r, irq_mask_nxt;
    logic [`RLS_IRQ_W-1:0]    events;
    logic [`RLS_IRQ_W-1:0]    rd_clr;
    logic [31:0]              rdata_r, rdata_nxt;
    logic                     err_r, err_nxt;
    logic                     lf_r, lf_nxt;
    logic                     any_serr_r, any_serr_nxt;
    logic                     any_spc_r, any_spc_nxt;
    logic                     any_rep_r, any_rep_nxt;
    logic                     setup;
    logic                     access;
    logic                     wr_en;
    logic                     rd_en;
    logic [LANES-1:0]         syn_w;
    logic [LANES-1:0]         serr_w;
    logic [LANES-1:0]         spc_w;
    logic [LANES-1:0]         rep_w;
    logic [2*LANES-1:0]       fval_w;
    logic [LANES-1:0]         fvld_w;

    // ----------------------------------------------------------------
    // per-lane trackers
    // ----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < LANES; g = g + 1) begin : g_lane
            rls_lane_track #(
                .INTV_W (INTV_W)
            ) u_lane (
                .clk                     (clk),
                .rst                     (rst),
                .lock_in                 (lane_lock[g]),
                .word_in                 (lane_word[g]),
                .marker_in               (lane_marker[g]),
                .marker_bad_in           (lane_marker_bad[g]),
                .ferr_cnt_in             (lane_ferr_cnt[2*g +: 2]),
                .ferr_stb_in             (lane_ferr_stb[g]),
                .marker_interval_setting (intv_r),
                .ferr_value              (fval_w[2*g +: 2]),
                .ferr_valid              (fvld_w[g]),
                .synced                  (syn_w[g]),
                .sync_err                (serr_w[g]),
                .marker_spacing_error    (spc_w[g]),
                .marker_repeat_error     (rep_w[g])
            );
        end
    endgenerate

    // one count field and one strobe per lane
    assign framing_err          = fval_w;
    assign framing_err_valid    = fvld_w;
    assign lane_synced          = syn_w;
    assign lane_sync_err        = serr_w;
    assign marker_spacing_error = spc_w;
    assign marker_repeat_error  = rep_w;

    // ----------------------------------------------------------------
    // apb decode
    // ----------------------------------------------------------------
    // zero wait states: every access completes in its first access cycle
    assign setup  = psel && !penable;
    assign access = psel && penable;
    assign wr_en  = access && pwrite && !err_r;
    assign rd_en  = access && !pwrite && !err_r;
    assign pready = 1'b1;

    // read data is captured in the setup cycle so it comes from a flop
    always_comb begin
        rdata_nxt = rdata_r;
        err_nxt   = err_r;
        if (setup) begin
            err_nxt   = 1'b0;
            rdata_nxt = 32'h0000_0000;
            case (paddr)
                `RLS_REG_CTRL: begin
                    rdata_nxt[INTV_W-1:0] = intv_r;
                end
                `RLS_REG_SYNCED: begin
                    rdata_nxt[LANES-1:0] = syn_w;
                end
                `RLS_REG_SYNCERR: begin
                    rdata_nxt[LANES-1:0] = serr_w;
                end
                `RLS_REG_SPACING: begin
                    rdata_nxt[LANES-1:0] = spc_w;
                end
                `RLS_REG_REPEAT: begin
                    rdata_nxt[LANES-1:0] = rep_w;
                end
                `RLS_REG_IRQ_ST: begin
                    rdata_nxt[`RLS_IRQ_W-1:0] = irq_st_r;
                end
                `RLS_REG_IRQ_MASK: begin
                    rdata_nxt[`RLS_IRQ_W-1:0] = irq_mask_r;
                end
                `RLS_REG_FAULT: begin
                    rdata_nxt[0] = lf_r;
                    rdata_nxt[1] = internal_local_fault;
                    rdata_nxt[2] = received_local_fault;
                end
                default: begin
                    err_nxt = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_r <= 32'h0000_0000;
            err_r   <= 1'b0;
        end else begin
            rdata_r <= rdata_nxt;
            err_r   <= err_nxt;
        end
    end

    assign prdata  = rdata_r;
    assign pslverr = access && err_r;

    // ----------------------------------------------------------------
    // writable registers
    // ----------------------------------------------------------------
    always_comb begin
        intv_nxt     = intv_r;
        irq_mask_nxt = irq_mask_r;
        if (wr_en && paddr == `RLS_REG_CTRL) begin
            intv_nxt = pwdata[INTV_W-1:0];
        end
        if (wr_en && paddr == `RLS_REG_IRQ_MASK) begin
            irq_mask_nxt = pwdata[`RLS_IRQ_W-1:0];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            intv_r     <= `RLS_INTV_RST;
            irq_mask_r <= `RLS_IRQ_MASK_RST;
        end else begin
            intv_r     <= intv_nxt;
            irq_mask_r <= irq_mask_nxt;
        end
    end

    // ----------------------------------------------------------------
    // local fault
    // ----------------------------------------------------------------
    always_comb begin
        lf_nxt = internal_local_fault || received_local_fault;
    end

    // ----------------------------------------------------------------
    // interrupt events and sticky status
    // ----------------------------------------------------------------
    always_comb begin
        any_serr_nxt = |serr_w;
        any_spc_nxt  = |spc_w;
        any_rep_nxt  = |rep_w;
        events                   = '0;
        events[`RLS_IRQ_SYNCERR] = any_serr_nxt && !any_serr_r;
        events[`RLS_IRQ_SPACING] = any_spc_nxt && !any_spc_r;
        events[`RLS_IRQ_REPEAT]  = any_rep_nxt && !any_rep_r;
        events[`RLS_IRQ_FAULT]   = lf_nxt && !lf_r;
        // only bits the read actually returned are cleared
        rd_clr = '0;
        if (rd_en && paddr == `RLS_REG_IRQ_ST) begin
            rd_clr = rdata_r[`RLS_IRQ_W-1:0];
        end
        // a new event wins over the clear in the same cycle
        irq_st_nxt = (irq_st_r & ~rd_clr) | events;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_st_r   <= '0;
            lf_r       <= 1'b0;
            any_serr_r <= 1'b0;
            any_spc_r  <= 1'b0;
            any_rep_r  <= 1'b0;
        end else begin
            irq_st_r   <= irq_st_nxt;
            lf_r       <= lf_nxt;
            any_serr_r <= any_serr_nxt;
            any_spc_r  <= any_spc_nxt;
            any_rep_r  <= any_rep_nxt;
        end
    end

    assign local_fault = lf_r;
    assign irq         = |(irq_st_r & irq_mask_r);

endmodule

// ---- rls_props.sv ----
// checker for the receive lane sync status ports
`include "rls_defines.svh"
module rls_props #(
    parameter int LANES  = `RLS_NUM_LANES,
    parameter int INTV_W = `RLS_INTV_W
) (
    // clock and reset
    input wire logic               clk,
    input wire logic               rst,
    // decoder side
    input wire logic [LANES-1:0]   lane_word,
    input wire logic [LANES-1:0]   lane_marker,
    input wire logic [2*LANES-1:0] lane_ferr_cnt,
    input wire logic [LANES-1:0]   lane_ferr_stb,
    input wire logic               internal_local_fault,
    input wire logic               received_local_fault,
    // status outputs
    input wire logic [2*LANES-1:0] framing_err,
    input wire logic [LANES-1:0]   framing_err_valid,
    input wire logic [LANES-1:0]   lane_synced,
    input wire logic [LANES-1:0]   lane_sync_err,
    input wire logic [LANES-1:0]   marker_spacing_error,
    input wire logic [LANES-1:0]   marker_repeat_error,
    input wire logic               local_fault
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    logic [2*LANES-1:0] vmask;
    logic [2*LANES-1:0] cmask;
    logic [2*LANES-1:0] cnt_m;
    logic [LANES-1:0]   mw;
    logic               flt_in;
    always_comb begin
        for (int i = 0; i < LANES; i++) begin
            vmask[2*i+:2] = {2{framing_err_valid[i]}};
            cmask[2*i+:2] = {2{lane_ferr_stb[i]}};
        end
    end
    assign cnt_m  = lane_ferr_cnt & cmask;
    assign mw     = lane_word & lane_marker;
    assign flt_in = internal_local_fault | received_local_fault;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // ----------------------------------------
    // properties
    // ----------------------------------------
    // flags lag the causing word by one edge; the checks also look two edges back, so two settled edges are needed
    sequence s_settled;
        !$past(rst) ##0 !$past(rst, 2);
    endsequence
    ferr_zero_a: assert property ((framing_err & ~vmask) == '0)
        else $error("count nonzero while strobe low");
    ferr_valid_a: assert property (
        !$past(rst) |-> framing_err_valid == $past(lane_ferr_stb))
        else $error("strobe not one cycle after input");
    ferr_value_a: assert property (!$past(rst) |-> framing_err == $past(cnt_m))
        else $error("count not one cycle after input");
    fault_or_a: assert property (!$past(rst) |-> local_fault == $past(flt_in))
        else $error("fault is not the or of sources");
    sync_excl_a: assert property ((lane_synced & lane_sync_err) == '0)
        else $error("synced and lock loss together");
    sync_rise_a: assert property (s_settled |->
        (lane_synced & ~$past(lane_synced) & ~$past(mw) & ~$past(mw, 2)) == '0)
        else $error("synced rose without a marker");
    spacing_rise_a: assert property (s_settled |-> (marker_spacing_error
        & ~$past(marker_spacing_error) & ~$past(lane_word) & ~$past(lane_word, 2)) == '0)
        else $error("spacing flag rose without a word");
    repeat_rise_a: assert property (s_settled |-> (marker_repeat_error
        & ~$past(marker_repeat_error) & ~$past(lane_word) & ~$past(lane_word, 2)) == '0)
        else $error("repeat flag rose without a word");
endmodule

bind rls_sync_status rls_props #(.LANES(LANES), .INTV_W(INTV_W)) u_props (
    .clk, .rst, .lane_word, .lane_marker, .lane_ferr_cnt, .lane_ferr_stb,
    .internal_local_fault, .received_local_fault, .framing_err, .framing_err_valid,
    .lane_synced, .lane_sync_err, .marker_spacing_error, .marker_repeat_error, .local_fault
);

// ---- rls_stat_model.sv ----
// statistics counter model fed by the framing error increments
module rls_stat_model #(
    parameter int LANES = 20
) (
    // clock and reset
    input  wire logic               clk,
    input  wire logic               rst,
    // increments from the block
    input  wire logic [2*LANES-1:0] framing_err,
    input  wire logic [LANES-1:0]   framing_err_valid,
    // running total over all lanes
    output logic [31:0]             err_total
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] err_total_nxt;
    always_comb begin
        err_total_nxt = err_total;
        for (int i = 0; i < LANES; i++) begin
            if (framing_err_valid[i]) begin
                err_total_nxt = err_total_nxt + 32'(framing_err[2*i+:2]);
            end
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            err_total <= 32'h0;
        end else begin
            err_total <= err_total_nxt;
        end
    end
endmodule

// ---- testbench.sv ----
// self-checking bench for the receive lane sync status block
`include "rls_defines.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int L = `RLS_NUM_LANES;
    localparam logic [L-1:0] ONES = '1;
    logic             clk, rst, psel, penable, pwrite, pready, pslverr, ifl, rfl, lflt, irq, e;
    logic [7:0]       paddr;
    logic [31:0]      pwdata, prdata, rd, tot, exp_tot;
    logic [L-1:0]     lock, word, mark, bad, stb, fvld, syn, serr, spc, rep, s;
    logic [2*L-1:0]   cnt, ferr, c;
    logic [3*L-1:0]   exp_q[$];
    int               n_mismatch, check_count;

    rls_sync_status u_dut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .lane_lock(lock), .lane_word(word), .lane_marker(mark),
        .lane_marker_bad(bad), .lane_ferr_cnt(cnt), .lane_ferr_stb(stb),
        .internal_local_fault(ifl), .received_local_fault(rfl), .framing_err(ferr),
        .framing_err_valid(fvld), .lane_synced(syn), .lane_sync_err(serr),
        .marker_spacing_error(spc), .marker_repeat_error(rep), .local_fault(lflt), .irq);
    rls_stat_model u_stat (.clk, .rst, .framing_err(ferr), .framing_err_valid(fvld),
        .err_total(tot));

    initial clk = 1'b0;
    always #50 clk = ~clk;

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // one apb transfer, entered just after an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        e = pslverr;
        if (n >= 20) begin
            n_mismatch++;
            finish_test();
        end
        psel <= 1'b0; penable <= 1'b0;
        @(posedge clk);
    endtask
    // gap plain words, then one marker word on every lane
    task automatic send(input int gap, input logic b);
        for (int i = 0; i <= gap; i++) begin
            word <= ONES; mark <= (i == gap) ? ONES : '0; bad <= (i == gap && b) ? ONES : '0;
            @(posedge clk);
        end
        word <= '0; mark <= '0; bad <= '0;
        repeat (2) @(posedge clk);
    endtask

    // ----------------------------------------
    // monitor: oldest note against each result
    // ----------------------------------------
    // sampled mid-cycle so the registered strobe has settled
    always @(negedge clk) begin
        if (!rst && fvld !== '0) begin
            if (exp_q.size() == 0) begin
                n_mismatch++;
                $display("[FAIL] %0t unexpected count", $time);
            end else begin
                chk(64'({fvld, ferr}), 64'(exp_q.pop_front()));
            end
        end
    end

    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        finish_test();
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {lock, word, mark, bad, stb, cnt, ifl, rfl} = '0;
        n_mismatch = 0; check_count = 0; exp_tot = 0; rst = 1'b1;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        void'($urandom(34));
        apb(0, `RLS_REG_CTRL, 0); chk(rd, 32'h3FFF);
        apb(0, `RLS_REG_IRQ_MASK, 0); chk(rd, 32'h0);
        apb(1, `RLS_REG_CTRL, 32'h3); apb(0, `RLS_REG_CTRL, 0); chk(rd, 32'h3);
        apb(0, 8'h20, 0); chk({e, rd}, {1'b1, 32'h0});
        // random framing counts, some idle cycles, back to back strobes
        repeat (60) begin
            s = ($urandom % 4 == 0) ? '0 : L'($urandom);
            c = 40'({$urandom, $urandom});
            for (int i = 0; i < L; i++) begin
                if (!s[i]) c[2*i+:2] = 2'h0;
                else exp_tot += 32'(c[2*i+:2]);
            end
            if (s != '0) exp_q.push_back({s, c});
            stb <= s; cnt <= c;
            @(posedge clk);
        end
        stb <= '0;
        repeat (4) @(posedge clk);
        chk(tot, exp_tot);
        chk(exp_q.size(), 0);
        // every fault combination, then interrupt raise, mask, clear
        for (int k = 0; k < 4; k++) begin
            ifl <= k[0]; rfl <= k[1];
            repeat (2) @(posedge clk);
            chk(lflt, k[0] | k[1]);
            apb(0, `RLS_REG_FAULT, 0);
            chk(rd, {k[1], k[0], k[0] | k[1]});
        end
        ifl <= 1'b0; rfl <= 1'b0;
        repeat (2) @(posedge clk);
        apb(0, `RLS_REG_IRQ_ST, 0);
        ifl <= 1'b1;
        repeat (3) @(posedge clk);
        chk(irq, 0);
        apb(1, `RLS_REG_IRQ_MASK, 32'h8); chk(irq, 1);
        apb(0, `RLS_REG_IRQ_ST, 0); chk(rd, 32'h8);
        chk(irq, 0);
        // lane lock, marker spacing and repeat errors on all lanes
        // locked words with no marker: one interval later the lane reports a missing marker
        lock <= ONES; word <= ONES;
        repeat (6) @(posedge clk);
        chk(serr, ONES);
        send(1, 0); send(3, 0); send(3, 0);
        chk(syn, ONES);
        chk({serr, spc, rep}, 60'h0);
        apb(0, `RLS_REG_SYNCED, 0);
        chk(rd, 32'(ONES));
        send(4, 0); chk(spc, ONES);
        send(3, 0); chk(spc, 0);
        repeat (3) send(3, 1);
        chk(rep, 0);
        send(3, 1); chk(rep, ONES);
        send(3, 0); chk(rep, 0);
        lock <= '0; word <= ONES;
        @(posedge clk);
        word <= '0;
        repeat (2) @(posedge clk);
        chk({syn, serr}, {20'h0, ONES});
        // lock loss, spacing and repeat rises all left their sticky bits
        apb(0, `RLS_REG_IRQ_ST, 0);
        chk(rd, 32'h7);
        finish_test();
    end
endmodule
